//--- logic/pci_target_defs.vh
// Purpose: constants for the PCI target access path
// Assumes: byte-addressed register port, 32-bit words
// Notes: register offsets and field positions are shared with software
`ifndef PCI_TARGET_DEFS_VH
`define PCI_TARGET_DEFS_VH
// ============================================================
// Bus commands seen in the address phase
`define CMD_IORD 4'h2
`define CMD_IOWR 4'h3
`define CMD_MEMRD 4'h6
`define CMD_MEMWR 4'h7
`define CMD_MEMRDM 4'hC
`define CMD_MEMRDL 4'hE
`define CMD_MWI 4'hF
// ============================================================
// Queue, burst and prefetch limits
`define WR_SLOTS 4'h7
`define BURST_LAST 4'h7
`define FIFO_WORDS 5'h10
`define WORD_STEP 32'h0000_0004
`define DISCARD_CLKS_DEF 32768
`define IO_MASK 24'hFF_FFFF
// ============================================================
// Register offsets
`define REG_CTRL 8'h00
`define REG_MEMBAR 8'h04
`define REG_MEMMASK 8'h08
`define REG_MEMWIN 8'h0C
`define REG_IOBAR 8'h10
`define REG_IOWIN 8'h14
`define REG_TIMERS 8'h18
`define REG_STATUS 8'h1C
// ============================================================
// Field positions and reset values
`define CTRL_DISCARD_OFF 0
`define CTRL_EAGER 1
`define WIN_SWAP 0
`define TMR_RETRY 7:0
`define TMR_DISC 15:8
`define ST_FLAG 0
`define ST_WRCNT 7:4
`define ST_PEND 8
`define ST_LOCK 9
`define RST_RETRY 8'h10
`define RST_DISC 8'h08
`endif

//--- logic/pci_target_local_access.v
// Purpose: PCI target path from external masters into the local bus
// Assumes: PCI pins and clock are asynchronous to mclk; master
//          changes pins just after its rising clock edge
// Notes: PCI pins are sampled at the middle of each PCI clock period
`timescale 1ns/1ns
`include "pci_target_defs.vh"
module pci_target_local_access #(
  parameter DISCARD_CLKS = `DISCARD_CLKS_DEF
) (
  input wire mclk,
  input wire arst_n,
  input wire pciClk,
  input wire pciFrameN,
  input wire pciIrdyN,
  input wire pciLockN,
  input wire [3:0] pciCbeN,
  input wire [31:0] pciAdIn,
  output reg [31:0] pciAdOut,
  output reg pciAdOeN,
  output reg pciDevselN,
  output reg pciTrdyN,
  output reg pciStopN,
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdData,
  output reg locReq,
  output reg locWrite,
  output reg [31:0] locAddr,
  output reg [31:0] locWrData,
  output reg [3:0] locBe,
  output reg locBurstStart,
  input wire locAck,
  input wire [31:0] locRdData
);
  localparam [5:0] S_IDLE = 6'b000001;
  localparam [5:0] S_WWAIT = 6'b000010;
  localparam [5:0] S_WDATA = 6'b000100;
  localparam [5:0] S_RWAIT = 6'b001000;
  localparam [5:0] S_RDATA = 6'b010000;
  localparam [5:0] S_TERM = 6'b100000;
  localparam [15:0] DISCARD_LOAD = DISCARD_CLKS[15:0] - 16'h0001;

  // ============================================================
  // Helpers
  function inWin;
    input [31:0] a;
    input [23:0] bar;
    input [23:0] mask;
    begin
      inWin = ((a[31:8] ^ bar) & mask) == 24'h00_0000;
    end
  endfunction

  // Upper bits from the window base under the mask, rest from PCI
  function [31:0] xlate;
    input [31:0] a;
    input [23:0] base;
    input [23:0] mask;
    begin
      xlate = {(base & mask) | (a[31:8] & ~mask), a[7:2], 2'b00};
    end
  endfunction

  function [31:0] swap32;
    input [31:0] d;
    input en;
    begin
      swap32 = en ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
    end
  endfunction

  // ============================================================
  // Pin synchronisers and PCI clock edge finder
  reg [39:0] syncA_r;
  reg [39:0] syncB_r;
  reg [39:0] syncC_r;
  reg clkLvl_r;
  reg [38:0] hold_r;
  wire pe = syncB_r[39] & syncC_r[39] & ~clkLvl_r;
  wire ne = ~syncB_r[39] & ~syncC_r[39] & clkLvl_r;

  // Pins latched mid-period, where they are stable, used at the rise
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncA_r <= 40'h00_0000_0000;
      syncB_r <= 40'h00_0000_0000;
      syncC_r <= 40'h00_0000_0000;
      clkLvl_r <= 1'b0;
      hold_r <= {3'b111, 36'h0_0000_0000};
    end
    else
    begin
      syncA_r <= {pciClk, pciFrameN, pciIrdyN, pciLockN, pciCbeN, pciAdIn};
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
      if (syncB_r[39] == syncC_r[39])
        clkLvl_r <= syncC_r[39];
      if (ne)
        hold_r <= syncC_r[38:0];
    end
  end

  wire hFrameN = hold_r[38];
  wire hIrdyN = hold_r[37];
  wire hLockN = hold_r[36];
  wire [3:0] hCbe = hold_r[35:32];
  wire [31:0] hAd = hold_r[31:0];

  // ============================================================
  // Software registers
  reg discardTimerOff_r;
  reg eager_r;
  reg [23:0] memBar_r;
  reg [23:0] memMask_r;
  reg [24:0] memWindowBaseReg_r;
  reg [23:0] ioBar_r;
  reg [24:0] ioWindowBaseReg_r;
  reg [7:0] firstDataWaitLimit_r;
  reg [7:0] discLimit_r;
  reg readDiscardedFlag_r;

  // ============================================================
  // Transaction state
  reg [5:0] st_r;
  reg [31:0] curPci_r;
  reg [31:0] curLoc_r;
  reg curIo_r;
  reg curSwap_r;
  reg curSwapRd_r;
  reg [3:0] cnt_r;
  reg [7:0] rtry_r;
  reg [7:0] disc_r;
  reg locked_r;
  reg pend_r;
  reg pendEpoch_r;
  reg [31:0] pendPci_r;
  reg [31:0] pendLoc_r;
  reg pendIo_r;
  reg [15:0] dcnt_r;
  reg [4:0] deliv_r;
  reg [4:0] fetchCnt_r;
  reg [3:0] cmtCnt_r;
  reg [3:0] retCnt_r;
  reg [2:0] wrTail_r;
  reg [2:0] wrHead_r;

  wire [3:0] cmd = hCbe;
  wire cmdIo = (cmd == `CMD_IORD) | (cmd == `CMD_IOWR);
  wire cmdWr = (cmd == `CMD_IOWR) | (cmd == `CMD_MEMWR) | (cmd == `CMD_MWI);
  wire cmdMemRd = (cmd == `CMD_MEMRD) | (cmd == `CMD_MEMRDM) |
                  (cmd == `CMD_MEMRDL);
  wire memHit = (cmdWr | cmdMemRd) & ~cmdIo & inWin(hAd, memBar_r, memMask_r);
  wire ioHit = cmdIo & inWin(hAd, ioBar_r, `IO_MASK);
  wire [31:0] aAlign = {hAd[31:2], 2'b00};
  wire [31:0] aLoc = ioHit ?
    xlate(aAlign, ioWindowBaseReg_r[24:1], `IO_MASK) :
    xlate(aAlign, memWindowBaseReg_r[24:1], memMask_r);
  wire aSwap = ioHit ? ioWindowBaseReg_r[`WIN_SWAP] :
    memWindowBaseReg_r[`WIN_SWAP];
  wire [3:0] wrUsed = cmtCnt_r - retCnt_r;
  wire slotFree = wrUsed < `WR_SLOTS;
  wire [31:0] nextPci = curPci_r + `WORD_STEP;
  // Leaving the window also covers running into a neighbouring one
  wire leave = curIo_r ? ~inWin(nextPci, ioBar_r, `IO_MASK) :
    ~inWin(nextPci, memBar_r, memMask_r);
  wire wTaken = pe & (st_r == S_WDATA) & ~hIrdyN & ~pciTrdyN;
  wire wLast = wTaken & (hFrameN | (cnt_r == `BURST_LAST) | leave);
  wire rTaken = pe & (st_r == S_RDATA) & ~hIrdyN & ~pciTrdyN;
  wire [4:0] delivNx = deliv_r + 5'h01;
  wire avail = fetchCnt_r > deliv_r;
  wire availNx = fetchCnt_r > delivNx;
  wire serving = (st_r == S_RWAIT) | (st_r == S_RDATA) | ~hFrameN;
  wire discardFire = pe & pend_r & ~discardTimerOff_r & ~serving &
                     (dcnt_r == 16'h0000);

  // Queue and FIFO storage, no reset needed
  reg [31:0] wrData_r [0:55];
  reg [3:0] wrBe_r [0:55];
  reg [31:0] wrAddr_r [0:6];
  reg [3:0] wrLen_r [0:6];
  reg [31:0] rdFifo_r [0:15];
  reg [2:0] drainW_r;
  wire fetchStore;

  // Write words land in the tail slot as they are taken
  always @(posedge mclk)
  begin
    if (wTaken)
    begin
      wrData_r[{wrTail_r, cnt_r[2:0]}] <= swap32(hAd, curSwap_r);
      wrBe_r[{wrTail_r, cnt_r[2:0]}] <= curSwap_r ?
        {~hCbe[0], ~hCbe[1], ~hCbe[2], ~hCbe[3]} : ~hCbe;
    end
    if (wLast)
    begin
      wrAddr_r[wrTail_r] <= curLoc_r;
      wrLen_r[wrTail_r] <= cnt_r + 4'h1;
    end
    if (fetchStore)
      rdFifo_r[fetchCnt_r[3:0]] <= swap32(locRdData, curSwapRd_r);
  end

  // ============================================================
  // Target sequencer, advanced once per PCI clock
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= S_IDLE;
      pciAdOut <= 32'h0000_0000;
      pciAdOeN <= 1'b1;
      pciDevselN <= 1'b1;
      pciTrdyN <= 1'b1;
      pciStopN <= 1'b1;
      curPci_r <= 32'h0000_0000;
      curLoc_r <= 32'h0000_0000;
      curIo_r <= 1'b0;
      curSwap_r <= 1'b0;
      curSwapRd_r <= 1'b0;
      cnt_r <= 4'h0;
      rtry_r <= 8'h00;
      disc_r <= 8'h00;
      locked_r <= 1'b0;
      pend_r <= 1'b0;
      pendEpoch_r <= 1'b0;
      pendPci_r <= 32'h0000_0000;
      pendLoc_r <= 32'h0000_0000;
      pendIo_r <= 1'b0;
      dcnt_r <= 16'h0000;
      deliv_r <= 5'h00;
      cmtCnt_r <= 4'h0;
      wrTail_r <= 3'h0;
    end
    else if (pe)
    begin
      // Discard timer only runs while the master is away
      if (discardFire)
        pend_r <= 1'b0;
      else if (pend_r & ~discardTimerOff_r & ~serving)
        dcnt_r <= dcnt_r - 16'h0001;
      if (wLast)
      begin
        cmtCnt_r <= cmtCnt_r + 4'h1;
        wrTail_r <= (wrTail_r == 3'h6) ? 3'h0 : wrTail_r + 3'h1;
      end
      case (st_r)
        S_IDLE:
        begin
          if (hFrameN & hLockN)
            locked_r <= 1'b0;
          if (~hFrameN & (memHit | ioHit))
          begin
            curPci_r <= aAlign;
            curLoc_r <= aLoc;
            curIo_r <= ioHit;
            curSwap_r <= aSwap;
            cnt_r <= 4'h0;
            rtry_r <= firstDataWaitLimit_r;
            disc_r <= discLimit_r;
            pciDevselN <= 1'b0;
            if (locked_r & hLockN)
            begin
              pciStopN <= 1'b0;
              st_r <= S_TERM;
            end
            else
            begin
              if (~hLockN)
                locked_r <= 1'b1;
              if (cmdWr)
              begin
                // Posted writes ignore any pending read
                pciTrdyN <= ~slotFree;
                st_r <= slotFree ? S_WDATA : S_WWAIT;
              end
              else if (pend_r)
              begin
                if (pendPci_r == aAlign && pendIo_r == ioHit)
                begin
                  dcnt_r <= DISCARD_LOAD;
                  st_r <= S_RWAIT;
                end
                else
                begin
                  pciStopN <= 1'b0;
                  st_r <= S_TERM;
                end
              end
              else
              begin
                pend_r <= 1'b1;
                pendEpoch_r <= ~pendEpoch_r;
                pendPci_r <= aAlign;
                pendLoc_r <= aLoc;
                pendIo_r <= ioHit;
                curSwapRd_r <= aSwap;
                deliv_r <= 5'h00;
                dcnt_r <= DISCARD_LOAD;
                st_r <= S_RWAIT;
              end
            end
          end
        end
        S_WWAIT:
        begin
          if (slotFree)
          begin
            pciTrdyN <= 1'b0;
            st_r <= S_WDATA;
          end
          else if (rtry_r == 8'h00)
          begin
            pciStopN <= 1'b0;
            st_r <= S_TERM;
          end
          else
            rtry_r <= rtry_r - 8'h01;
        end
        S_WDATA:
        begin
          if (wTaken)
          begin
            cnt_r <= cnt_r + 4'h1;
            disc_r <= discLimit_r;
            curPci_r <= nextPci;
            if (hFrameN)
            begin
              pciTrdyN <= 1'b1;
              pciDevselN <= 1'b1;
              st_r <= S_IDLE;
            end
            else if (wLast)
            begin
              pciTrdyN <= 1'b1;
              pciStopN <= 1'b0;
              st_r <= S_TERM;
            end
          end
          else if (hFrameN & hIrdyN)
          begin
            pciTrdyN <= 1'b1;
            pciDevselN <= 1'b1;
            st_r <= S_IDLE;
          end
        end
        S_RWAIT:
        begin
          if (avail)
          begin
            pciAdOut <= rdFifo_r[deliv_r[3:0]];
            pciAdOeN <= 1'b0;
            pciTrdyN <= 1'b0;
            disc_r <= discLimit_r;
            st_r <= S_RDATA;
          end
          else if (rtry_r == 8'h00)
          begin
            pciStopN <= 1'b0;
            st_r <= S_TERM;
          end
          else
            rtry_r <= rtry_r - 8'h01;
        end
        S_RDATA:
        begin
          if (rTaken)
          begin
            deliv_r <= delivNx;
            cnt_r <= cnt_r + 4'h1;
            disc_r <= discLimit_r;
            curPci_r <= nextPci;
            if (hFrameN)
            begin
              pend_r <= 1'b0;
              pciTrdyN <= 1'b1;
              pciAdOeN <= 1'b1;
              pciDevselN <= 1'b1;
              st_r <= S_IDLE;
            end
            else if ((cnt_r == `BURST_LAST) | leave)
            begin
              pend_r <= 1'b0;
              pciTrdyN <= 1'b1;
              pciAdOeN <= 1'b1;
              pciStopN <= 1'b0;
              st_r <= S_TERM;
            end
            else
            begin
              pciAdOut <= rdFifo_r[delivNx[3:0]];
              pciTrdyN <= ~availNx;
            end
          end
          else if (pciTrdyN)
          begin
            if (avail)
            begin
              pciAdOut <= rdFifo_r[deliv_r[3:0]];
              pciTrdyN <= 1'b0;
              disc_r <= discLimit_r;
            end
            else if (disc_r == 8'h00)
            begin
              pend_r <= 1'b0;
              pciAdOeN <= 1'b1;
              pciStopN <= 1'b0;
              st_r <= S_TERM;
            end
            else
              disc_r <= disc_r - 8'h01;
          end
        end
        S_TERM:
        begin
          pciTrdyN <= 1'b1;
          pciAdOeN <= 1'b1;
          if (hFrameN)
          begin
            pciStopN <= 1'b1;
            pciDevselN <= 1'b1;
            st_r <= S_IDLE;
          end
        end
        default:
          st_r <= S_IDLE;
      endcase
    end
  end

  // ============================================================
  // Local bus engine: drains posted writes first, then fetches reads
  reg busy_r;
  reg busyWr_r;
  reg seenEpoch_r;
  reg issueEpoch_r;
  // Eager fill outlives the read that started it, so one word brings 16
  reg fill_r;
  wire fillOn = pend_r | fill_r;
  wire [4:0] fetchLim = (eager_r & ~pendIo_r) ? `FIFO_WORDS :
    ((delivNx > `FIFO_WORDS) ? `FIFO_WORDS : delivNx);
  wire canFetch = fillOn & (seenEpoch_r == pendEpoch_r) &
                  (fetchCnt_r < fetchLim);
  assign fetchStore = busy_r & ~busyWr_r & locAck & fillOn &
                      (issueEpoch_r == pendEpoch_r);

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      locReq <= 1'b0;
      locWrite <= 1'b0;
      locAddr <= 32'h0000_0000;
      locWrData <= 32'h0000_0000;
      locBe <= 4'h0;
      locBurstStart <= 1'b0;
      busy_r <= 1'b0;
      busyWr_r <= 1'b0;
      seenEpoch_r <= 1'b0;
      issueEpoch_r <= 1'b0;
      fill_r <= 1'b0;
      fetchCnt_r <= 5'h00;
      drainW_r <= 3'h0;
      retCnt_r <= 4'h0;
      wrHead_r <= 3'h0;
    end
    else
    begin
      locBurstStart <= 1'b0;
      if (seenEpoch_r != pendEpoch_r)
      begin
        seenEpoch_r <= pendEpoch_r;
        fetchCnt_r <= 5'h00;
        fill_r <= eager_r & ~pendIo_r;
      end
      else if (fetchStore)
        fetchCnt_r <= fetchCnt_r + 5'h01;
      if (busy_r)
      begin
        if (locAck)
        begin
          locReq <= 1'b0;
          busy_r <= 1'b0;
          if (busyWr_r)
          begin
            drainW_r <= drainW_r + 3'h1;
            if ({1'b0, drainW_r} + 4'h1 == wrLen_r[wrHead_r])
            begin
              drainW_r <= 3'h0;
              retCnt_r <= retCnt_r + 4'h1;
              wrHead_r <= (wrHead_r == 3'h6) ? 3'h0 : wrHead_r + 3'h1;
            end
          end
        end
      end
      else if (wrUsed != 4'h0)
      begin
        // Partial writes: byte enables go through as stored, lane-reversed for a swapped window
        locReq <= 1'b1;
        locWrite <= 1'b1;
        locAddr <= wrAddr_r[wrHead_r] + {27'h0, drainW_r, 2'b00};
        locWrData <= wrData_r[{wrHead_r, drainW_r}];
        locBe <= wrBe_r[{wrHead_r, drainW_r}];
        locBurstStart <= (drainW_r == 3'h0);
        busy_r <= 1'b1;
        busyWr_r <= 1'b1;
      end
      else if (canFetch)
      begin
        // Each run of eight words is one local burst
        locReq <= 1'b1;
        locWrite <= 1'b0;
        locAddr <= pendLoc_r + {25'h0, fetchCnt_r, 2'b00};
        locBe <= 4'hF;
        locBurstStart <= (fetchCnt_r[2:0] == 3'h0);
        busy_r <= 1'b1;
        busyWr_r <= 1'b0;
        issueEpoch_r <= pendEpoch_r;
      end
    end
  end

  // ============================================================
  // Register port; read data valid only in the cycle after the strobe
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      discardTimerOff_r <= 1'b0;
      eager_r <= 1'b0;
      memBar_r <= 24'h00_0000;
      memMask_r <= 24'h00_0000;
      memWindowBaseReg_r <= 25'h000_0000;
      ioBar_r <= 24'h00_0000;
      ioWindowBaseReg_r <= 25'h000_0000;
      firstDataWaitLimit_r <= `RST_RETRY;
      discLimit_r <= `RST_DISC;
      readDiscardedFlag_r <= 1'b0;
      regRdData <= 32'h0000_0000;
    end
    else
    begin
      // Set wins over a simultaneous write-one clear
      readDiscardedFlag_r <= discardFire | (readDiscardedFlag_r &
        ~(regWr & (regAddr == `REG_STATUS) & regWrData[`ST_FLAG]));
      if (regWr)
      begin
        case (regAddr)
          `REG_CTRL:
          begin
            discardTimerOff_r <= regWrData[`CTRL_DISCARD_OFF];
            eager_r <= regWrData[`CTRL_EAGER];
          end
          `REG_MEMBAR: memBar_r <= regWrData[31:8];
          `REG_MEMMASK: memMask_r <= regWrData[31:8];
          `REG_MEMWIN: memWindowBaseReg_r <= {regWrData[31:8],
            regWrData[`WIN_SWAP]};
          `REG_IOBAR: ioBar_r <= regWrData[31:8];
          `REG_IOWIN: ioWindowBaseReg_r <= {regWrData[31:8],
            regWrData[`WIN_SWAP]};
          `REG_TIMERS:
          begin
            firstDataWaitLimit_r <= regWrData[`TMR_RETRY];
            discLimit_r <= regWrData[`TMR_DISC];
          end
          default: ;
        endcase
      end
      regRdData <= 32'h0000_0000;
      if (regRd)
      begin
        case (regAddr)
          `REG_CTRL: regRdData <= {30'h0, eager_r, discardTimerOff_r};
          `REG_MEMBAR: regRdData <= {memBar_r, 8'h00};
          `REG_MEMMASK: regRdData <= {memMask_r, 8'h00};
          `REG_MEMWIN: regRdData <= {memWindowBaseReg_r[24:1], 7'h00,
            memWindowBaseReg_r[0]};
          `REG_IOBAR: regRdData <= {ioBar_r, 8'h00};
          `REG_IOWIN: regRdData <= {ioWindowBaseReg_r[24:1], 7'h00,
            ioWindowBaseReg_r[0]};
          `REG_TIMERS: regRdData <= {16'h0000, discLimit_r,
            firstDataWaitLimit_r};
          `REG_STATUS: regRdData <= {22'h0, locked_r, pend_r, wrUsed,
            3'h0, readDiscardedFlag_r};
          default: regRdData <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

//--- sim/local_mem_model.sv
// Purpose: local bus slave behind the target path
// Assumes: one request outstanding at a time
// Notes: lat gives the ack delay in mclk cycles
`timescale 1ns/1ns
module local_mem_model (
  input wire mclk,
  input wire locReq,
  input wire locWrite,
  input wire [31:0] locAddr,
  input wire [31:0] locWrData,
  input wire [11:0] lat,
  output logic locAck = 1'b0,
  output logic [31:0] locRdData = 32'h0,
  output logic [31:0] lastAddr = 32'h0,
  output logic [31:0] lastData = 32'h0
);
  // ====================================================
  // Responder
  logic [11:0] cnt_r = 12'h000;
  // Ack after lat cycles; read data is address based
  always @(posedge mclk)
  begin
    locAck <= 1'b0;
    locRdData <= ~locRdData; // Stale data never looks valid
    if (locReq && !locAck && cnt_r >= lat)
    begin
      cnt_r <= 12'h000;
      locAck <= 1'b1;
      locRdData <= locAddr ^ 32'hA5A5_0000;
      lastAddr <= locWrite ? locAddr : lastAddr;
      lastData <= locWrite ? locWrData : lastData;
    end
    else if (locReq && !locAck)
      cnt_r <= cnt_r + 12'h001;
  end
endmodule

//--- sim/pci_target_local_access_props.sv
// Purpose: port-level checks of the PCI target access path
// Assumes: ports as declared by the design top
// Notes: bound at the foot of this file
`timescale 1ns/1ns
module pci_target_local_access_props (
  input wire mclk,
  input wire arst_n,
  input wire pciAdOeN,
  input wire pciDevselN,
  input wire pciTrdyN,
  input wire pciStopN,
  input wire locReq,
  input wire locWrite,
  input wire [31:0] locAddr,
  input wire [3:0] locBe,
  input wire locBurstStart,
  input wire locAck
);
  // ====================================================
  // Local bus handshake and PCI response checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  AST_LOCHOLD: assert property (
    locReq && !locAck |=> locReq && $stable(locAddr) && $stable(locBe))
    else $error("local request changed before ack");
  AST_LOCDROP: assert property (
    locReq && locAck |=> !locReq)
    else $error("local request held after ack");
  AST_ALIGN: assert property (
    locReq |-> locAddr[1:0] == 2'h0)
    else $error("local address not word aligned");
  AST_RDLANES: assert property (
    locReq && !locWrite |-> locBe == 4'hF)
    else $error("local read without all lanes");
  AST_BSTART: assert property (
    locBurstStart |-> locReq ##1 !locBurstStart)
    else $error("burst start not a single request cycle");
  AST_TRDYSEL: assert property (
    !pciTrdyN |-> !pciDevselN)
    else $error("ready given without select");
  AST_STOPSEL: assert property (
    $fell(pciStopN) |-> !pciDevselN)
    else $error("stop given without select");
  AST_OESEL: assert property (
    !pciAdOeN |-> !pciDevselN && pciStopN || !pciTrdyN)
    else $error("data driven outside a selected read");
endmodule
bind pci_target_local_access pci_target_local_access_props u_props (
  .mclk, .arst_n, .pciAdOeN, .pciDevselN, .pciTrdyN, .pciStopN,
  .locReq, .locWrite, .locAddr, .locBe, .locBurstStart, .locAck);

//--- sim/tb_top.sv
// Purpose: bench for the PCI target access path
// Assumes: free-running PCI clock, single-word transfers
// Notes: short discard count keeps the run brief
`timescale 1ns/1ns
`include "pci_target_defs.vh"
module tb_top;
  logic mclk = 0, arst_n = 0, pciClk = 0, regWr = 0, regRd = 0;
  logic pciFrameN = 1, pciIrdyN = 1, pciLockN = 1, lk = 1, ok;
  logic [3:0] pciCbeN = 4'hF;
  logic [7:0] regAddr = 8'h00;
  logic [11:0] lat = 12'h002;
  logic [31:0] mAd = 32'h0, regWrData = 32'h0, q;
  wire [31:0] pciAdOut, regRdData, locAddr, locWrData, locRdData, lA, lD;
  wire [3:0] locBe;
  wire pciAdOeN, pciDevselN, pciTrdyN, pciStopN, locReq, locWrite;
  wire locBurstStart, locAck;
  wire [31:0] pciAdIn = pciAdOeN ? mAd : pciAdOut; // Shared AD wire
  int num_errors = 0, n_checks = 0, bursts = 0, b;
  pci_target_local_access #(.DISCARD_CLKS(64)) uut (.mclk, .arst_n,
    .pciClk, .pciFrameN, .pciIrdyN, .pciLockN, .pciCbeN,
    .pciAdIn, .pciAdOut, .pciAdOeN, .pciDevselN, .pciTrdyN, .pciStopN,
    .regAddr, .regWrData, .regWr, .regRd, .regRdData, .locReq,
    .locWrite, .locAddr, .locWrData, .locBe, .locBurstStart, .locAck,
    .locRdData);
  local_mem_model mem (.mclk, .locReq, .locWrite, .locAddr, .locWrData,
    .lat, .locAck, .locRdData, .lastAddr(lA), .lastData(lD));
  // ====================================================
  // Clocks; PCI clock offset so its edges miss mclk edges
  initial forever #2 mclk = ~mclk;
  initial #7 forever #32 pciClk = ~pciClk;
  // Local burst starts
  always @(posedge mclk) if (locBurstStart === 1'b1) bursts++;
  // ====================================================
  // Tasks
  task chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task rw(input [7:0] a, input [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task rc(input [7:0] a, input [31:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 chk(regRdData, e);
  endtask
  // One data phase; ok tells data taken, else retried
  task pci(input [3:0] c, input [31:0] a, d);
    int n;
    repeat (2) @(posedge pciClk);
    pciFrameN <= 1'b0;
    mAd <= a;
    pciCbeN <= c;
    pciLockN <= lk;
    @(posedge pciClk);
    pciFrameN <= 1'b1;
    pciIrdyN <= 1'b0;
    mAd <= d;
    pciCbeN <= 4'h0;
    n = 0;
    do
    begin
      @(posedge pciClk);
      n++;
    end
    while (pciTrdyN !== 1'b0 && pciStopN !== 1'b0 && n < 40);
    ok = (pciTrdyN === 1'b0);
    q = pciAdOut;
    pciIrdyN <= 1'b1;
    mAd <= ~d; // Released lines show no old value
  endtask
  task lw(input [31:0] a, d);
    int n;
    for (n = 0; n < 9000 && lA !== a; n++)
      @(posedge mclk);
    chk(lA, a);
    chk(lD, d);
  endtask
  task results;
    if (num_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog, far beyond the expected run
  initial
  begin
    #200000;
    num_errors++;
    results;
  end
  // ====================================================
  // Main sequence
  initial
  begin
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    rc(`REG_TIMERS, 32'h0000_0810);
    rc(`REG_STATUS, 32'h0);
    rc(8'hFC, 32'h0);
    rw(`REG_MEMBAR, 32'h1000_0000);
    rw(`REG_MEMMASK, 32'hFFFF_FF00);
    rw(`REG_MEMWIN, 32'h2000_0000);
    rw(`REG_IOBAR, 32'h3000_0000);
    rw(`REG_IOWIN, 32'h4000_0001);
    rc(`REG_IOWIN, 32'h4000_0001);
    pci(`CMD_MEMWR, 32'h1000_0046, 32'h1122_3344);
    chk(ok, 32'h1);
    lw(32'h2000_0044, 32'h1122_3344);
    pci(`CMD_IOWR, 32'h3000_0008, 32'h1122_3344);
    lw(32'h4000_0008, 32'h4433_2211);
    // Slow local bus holds the first write, so the queue fills up
    lat <= 12'h7D0;
    for (b = 0; b < 8; b++)
    begin
      pci(`CMD_MEMWR, 32'h1000_0020, 32'h0);
      chk(ok, {31'h0, b < 7});
    end
    lat <= 12'h002;
    // Lock owner passes; a master without lock is retried
    lk = 1'b0;
    pci(`CMD_MEMWR, 32'h1000_0030, 32'h0);
    chk(ok, 32'h1);
    lk = 1'b1;
    pci(`CMD_MEMWR, 32'h1000_0030, 32'h0);
    chk(ok, 32'h0);
    pci(`CMD_MEMRD, 32'h1000_0080, 32'h0);
    chk(q, 32'h85A5_0080);
    // Slow local bus forces a delayed read
    lat <= 12'h7D0;
    pci(`CMD_MEMRD, 32'h1000_00C0, 32'h0);
    chk(ok, 32'h0);
    lat <= 12'h002;
    rc(`REG_STATUS, 32'h0000_0100);
    pci(`CMD_MEMRD, 32'h1000_0100, 32'h0);
    chk(ok, 32'h0);
    pci(`CMD_MEMWR, 32'h1000_0010, 32'h5566_7788);
    chk(ok, 32'h1);
    repeat (150) @(posedge pciClk);
    rc(`REG_STATUS, 32'h1);
    rw(`REG_STATUS, 32'h1);
    rc(`REG_STATUS, 32'h0);
    rw(`REG_CTRL, 32'h1);
    lat <= 12'h7D0;
    pci(`CMD_MEMRD, 32'h1000_00C0, 32'h0);
    lat <= 12'h002;
    repeat (150) @(posedge pciClk);
    rc(`REG_STATUS, 32'h0000_0100);
    pci(`CMD_MEMRD, 32'h1000_00C0, 32'h0);
    chk(q, 32'h85A5_00C0);
    rw(`REG_CTRL, 32'h2);
    b = bursts;
    pci(`CMD_MEMRD, 32'h1000_0000, 32'h0); // Far from memory top
    repeat (60) @(posedge pciClk);
    chk(bursts - b, 32'h2);
    results;
  end
endmodule
